// ===== hdl/gpio_pkg.sv
// constants and carrier types for the eight-pin general-purpose port
// What this block does
// - eight pins, each input, interrupt input or output
// - bit X of the data, direction and option registers drives pin X
// - direction bit clear gives input, read returns pin
// - data write in input mode only updates latch
// - option bit picks floating/interrupt or open-drain/push-pull
// - each interrupt pin raises request, sensitivity held in the port's own SENS register
// - enabled group pins combine by NAND then invert
// - disabled pin forces detector input high
// - request latch hidden, cleared on vector fetch
// - direction bit set drives latch, read returns pin
// - latch 0 drives low, 1 high or floating
// - peripheral claim overrides direction and option
// - peripheral output forces output with its drive type
// - separately powered pins held low without rail
// - input pin with alternate output reads alternate value
// - output pin with alternate input feeds latch value
package gpio_pkg;
	localparam int unsigned PINS = 8;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_DIR = 8'h04;
	localparam logic [7:0] ADDR_OPT = 8'h08;
	localparam logic [7:0] ADDR_SENS = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] SENS_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE = 2'h1;
	localparam logic [1:0] SENS_FALL = 2'h2;
	localparam logic [1:0] SENS_BOTH = 2'h3;

	// alternate function claim for the whole port, one bit per pin
	typedef struct packed {
		logic [7:0] claim;
		logic [7:0] is_out;
		logic [7:0] push_pull;
		logic [7:0] out_val;
	} alt_s;

	// pad drive, oe low means the pad is driven
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} pad_s;
endpackage : gpio_pkg

// ===== hdl/pin_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int unsigned W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	if (W == 0) begin : g_bad_width
		$error("width must be nonzero");
	end

	always_comb begin
		meta_nxt = d;
		q_nxt = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule : pin_sync
`default_nettype wire

// ===== hdl/irq_edge.sv
// edge or level detector with a request latch cleared on vector fetch
`timescale 1ns/1ps
`default_nettype none
module irq_edge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic det_in,
	input wire logic [1:0] sens,
	input wire logic vector_fetch,
	output logic req
);
	logic prev_r;
	logic prev_nxt;
	logic req_r;
	logic req_nxt;
	logic hit;

	always_comb begin
		prev_nxt = det_in;
		hit = 1'b0;
		unique case (sens)
			gpio_pkg::SENS_FALL_LOW: hit = !det_in;
			gpio_pkg::SENS_RISE: hit = det_in && !prev_r;
			gpio_pkg::SENS_FALL: hit = !det_in && prev_r;
			gpio_pkg::SENS_BOTH: hit = det_in != prev_r;
		endcase
		// a new event in the fetch cycle wins over the clear
		req_nxt = hit | (req_r & ~vector_fetch);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// idle level high so the first compare sees no edge
			prev_r <= 1'b1;
			req_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			req_r <= req_nxt;
		end
	end

	assign req = req_r;
endmodule : irq_edge
`default_nettype wire

// ===== hdl/gpio_port.sv
// eight-pin port with AXI4-Lite registers, alternate functions and external interrupt
`timescale 1ns/1ps
`default_nettype none
module gpio_port #(
	parameter int unsigned PINS = gpio_pkg::PINS,
	parameter logic [7:0] SUPPLY_PINS = 8'h00,
	parameter logic [7:0] GROUP_PINS = 8'hFF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pin_in,
	output gpio_pkg::pad_s pad,
	input wire gpio_pkg::alt_s alt,
	output logic [7:0] alt_in,
	input wire logic io_supply_ok,
	input wire logic vector_fetch,
	output logic ext_irq
);
	logic rst_s1_r;
	logic rst_n_r;
	logic [7:0] pin_s;
	logic [7:0] data_r;
	logic [7:0] data_nxt;
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] opt_r;
	logic [7:0] opt_nxt;
	logic [1:0] sens_r;
	logic [1:0] sens_nxt;
	logic [7:0] aw_r;
	logic [7:0] aw_nxt;
	logic aw_ok_r;
	logic aw_ok_nxt;
	logic [31:0] wd_r;
	logic [31:0] wd_nxt;
	logic [3:0] ws_r;
	logic [3:0] ws_nxt;
	logic w_ok_r;
	logic w_ok_nxt;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic [7:0] eff_dir;
	logic [7:0] eff_pp;
	logic [7:0] eff_val;
	logic [7:0] irq_en;
	logic [7:0] rd_view;
	logic det_in;
	logic [7:0] pad_out_r;
	logic [7:0] pad_out_nxt;
	logic [7:0] pad_oe_n_r;
	logic [7:0] pad_oe_n_nxt;
	logic [7:0] alt_in_r;
	logic [7:0] alt_in_nxt;
	logic do_write;

	// pins above the parameter count are absent: never enabled, read as zero in the data register
	function automatic logic [7:0] used_mask(input int unsigned n);
		used_mask = 8'h00;
		for (int i = 0; i < gpio_pkg::PINS; i++) begin
			if (i < n) begin
				used_mask[i] = 1'b1;
			end
		end
	endfunction : used_mask

	localparam logic [7:0] USED = used_mask(PINS);

	if (PINS == 0 || PINS > gpio_pkg::PINS) begin : g_bad_pins
		$error("port holds one to eight pins");
	end
	if ((SUPPLY_PINS & ~USED) != 8'h00) begin : g_bad_supply
		$error("rail powered pins lie beyond the port width");
	end

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == gpio_pkg::ADDR_DATA) || (a == gpio_pkg::ADDR_DIR) ||
			(a == gpio_pkg::ADDR_OPT) || (a == gpio_pkg::ADDR_SENS) ||
			(a == gpio_pkg::ADDR_STAT);
	endfunction : mapped

	// registers sit in byte lane 0; the upper lanes read as zero, save status bit 8 (detector input)
	function automatic logic [31:0] lane0(input logic [7:0] b);
		lane0 = {24'h000000, b};
	endfunction : lane0

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	pin_sync #(
		.W(8)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n_r),
		.d(pin_in),
		.q(pin_s)
	);

	// pin configuration after peripheral override
	always_comb begin
		eff_dir = (dir_r & ~alt.claim) | (alt.claim & alt.is_out);
		eff_pp = (opt_r & ~alt.claim) | (alt.claim & alt.push_pull);
		eff_val = (data_r & ~(alt.claim & alt.is_out)) | (alt.claim & alt.is_out & alt.out_val);
		irq_en = ~dir_r & opt_r & ~alt.claim & GROUP_PINS & USED;
		// an input claimed for an alternate output reads the peripheral's value
		rd_view = (pin_s & ~(alt.claim & alt.is_out & ~dir_r)) |
			(alt.out_val & alt.claim & alt.is_out & ~dir_r);
		// input pins of the peripheral see the latch when the port is in output
		alt_in_nxt = (pin_s & ~dir_r) | (data_r & dir_r);
		// disabled pins look high, so one enabled low pin masks the group
		det_in = &(pin_s | ~irq_en);
	end

	always_comb begin
		pad_out_nxt = '0;
		pad_oe_n_nxt = '1;
		for (int i = 0; i < 8; i++) begin
			if (i < PINS && eff_dir[i]) begin
				if (!eff_val[i]) begin
					pad_out_nxt[i] = 1'b0;
					pad_oe_n_nxt[i] = 1'b0;
				end else if (eff_pp[i]) begin
					pad_out_nxt[i] = 1'b1;
					pad_oe_n_nxt[i] = 1'b0;
				end
			end
			// no rail: the pin is tied to ground whatever the configuration
			if (SUPPLY_PINS[i] && (!io_supply_ok || !rst_n_r)) begin
				pad_out_nxt[i] = 1'b0;
				pad_oe_n_nxt[i] = 1'b0;
			end
		end
	end

	irq_edge u_irq (
		.clk(clk),
		.rst_n(rst_n_r),
		.det_in(det_in),
		.sens(sens_r),
		.vector_fetch(vector_fetch),
		.req(ext_irq)
	);

	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		aw_nxt = aw_r;
		aw_ok_nxt = aw_ok_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		w_ok_nxt = w_ok_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		data_nxt = data_r;
		dir_nxt = dir_r;
		opt_nxt = opt_r;
		sens_nxt = sens_r;
		// the write waits for both halves, so a lone address never lands
		do_write = aw_ok_r && w_ok_r && !bvalid_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = s_axi_awaddr;
			aw_ok_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
			w_ok_nxt = 1'b1;
		end
		if (do_write) begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped(aw_r) ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
			if (ws_r[0]) begin
				unique case (aw_r)
					// data writes always reach the latch, whatever the direction
					gpio_pkg::ADDR_DATA: data_nxt = wd_r[7:0];
					gpio_pkg::ADDR_DIR: dir_nxt = wd_r[7:0];
					gpio_pkg::ADDR_OPT: opt_nxt = wd_r[7:0];
					gpio_pkg::ADDR_SENS: sens_nxt = wd_r[1:0];
					default: ;
				endcase
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = mapped(s_axi_araddr) ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				gpio_pkg::ADDR_DATA: rdata_nxt = lane0(rd_view & USED);
				gpio_pkg::ADDR_DIR: rdata_nxt = lane0(dir_r);
				gpio_pkg::ADDR_OPT: rdata_nxt = lane0(opt_r);
				gpio_pkg::ADDR_SENS: rdata_nxt = {30'h00000000, sens_r};
				gpio_pkg::ADDR_STAT: rdata_nxt = {23'h000000, det_in, eff_dir};
				default: rdata_nxt = 32'h00000000;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	assign s_axi_awready = !aw_ok_r && !bvalid_r;
	assign s_axi_wready = !w_ok_r && !bvalid_r;
	// one read in flight: a new address waits until the answer is taken
	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			aw_r <= 8'h00;
			aw_ok_r <= 1'b0;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
			w_ok_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= gpio_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= gpio_pkg::RESP_OKAY;
			data_r <= gpio_pkg::RESET_BYTE;
			dir_r <= gpio_pkg::RESET_BYTE;
			opt_r <= gpio_pkg::RESET_BYTE;
			sens_r <= gpio_pkg::SENS_RESET;
		end else begin
			aw_r <= aw_nxt;
			aw_ok_r <= aw_ok_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			w_ok_r <= w_ok_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			data_r <= data_nxt;
			dir_r <= dir_nxt;
			opt_r <= opt_nxt;
			sens_r <= sens_nxt;
		end
	end

	// pad drive registered; the raw reset forces rail-powered pins low at once, whatever io_supply_ok says
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pad_out_r <= 8'h00;
			pad_oe_n_r <= ~SUPPLY_PINS;
			alt_in_r <= 8'h00;
		end else begin
			pad_out_r <= pad_out_nxt;
			pad_oe_n_r <= pad_oe_n_nxt;
			alt_in_r <= alt_in_nxt;
		end
	end

	assign pad.out = pad_out_r;
	assign pad.oe_n = pad_oe_n_r;
	assign alt_in = alt_in_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule : gpio_port
`default_nettype wire

// ===== verification/gpio_port_assertions.sv
// checker for the port's bus answers, pad drive and request latch
`timescale 1ns/1ps
`default_nettype none
module gpio_port_assertions #(
	parameter logic [7:0] SUPPLY_PINS = 8'h00
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [7:0] pin_in,
	input wire gpio_pkg::pad_s pad,
	input wire gpio_pkg::alt_s alt,
	input wire logic io_supply_ok,
	input wire logic vector_fetch,
	input wire logic ext_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] drv;
	// rail-powered pins are left out: their ground hold beats any claim
	assign drv = alt.claim & alt.is_out & ~SUPPLY_PINS;

	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > gpio_pkg::ADDR_STAT |=> s_axi_rresp == gpio_pkg::RESP_SLVERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read accepted");
	supply_low_a: assert property (!io_supply_ok [*2] |->
		(SUPPLY_PINS & (pad.out | pad.oe_n)) == 8'h00) else $error("unpowered pin not low");
	alt_drive_a: assert property ($stable(alt) [*6] |->
		((pad.out ^ alt.out_val) & drv & ~pad.oe_n) == 8'h00
		&& ((pad.oe_n ^ (~alt.push_pull & alt.out_val)) & drv) == 8'h00)
		else $error("peripheral drive wrong");
	pin_read_a: assert property (($stable(pin_in) && $stable(alt)) [*4] ##0
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == gpio_pkg::ADDR_DATA)
		|=> ((s_axi_rdata[7:0] ^ $past(pin_in)) & ~$past(alt.claim & alt.is_out)) == 8'h00)
		else $error("data read not pin level");
	irq_clear_a: assert property ($fell(ext_irq) |-> $past(vector_fetch))
		else $error("request dropped without fetch");
endmodule : gpio_port_assertions
bind gpio_port gpio_port_assertions #(.SUPPLY_PINS(SUPPLY_PINS)) i_chk (
	.clk(clk),
	.reset_n(reset_n),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.pin_in(pin_in),
	.pad(pad),
	.alt(alt),
	.io_supply_ok(io_supply_ok),
	.vector_fetch(vector_fetch),
	.ext_irq(ext_irq)
);
`default_nettype wire

// ===== verification/pin_model.sv
// outside world at the pins: board level, strong sink, pad drive
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	input wire gpio_pkg::pad_s pad,
	input wire logic [7:0] ext,
	input wire logic [7:0] sink,
	output logic [7:0] pin_in
);
	// a floating pad shows the board level; the sink beats any drive
	assign pin_in = ((pad.oe_n & ext) | (~pad.oe_n & pad.out)) & ~sink;
endmodule : pin_model
`default_nettype wire

// ===== verification/gpio_port_with_ext_interrupt_test.sv
// self-checking bench for the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_ext_interrupt_test;
	typedef struct packed {
		logic [7:0] dir, opt, dat, ext, oen, rd;
	} row_s;
	logic clk, reset_n, io_supply_ok, vector_fetch, ext_irq;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pin_in, alt_in, ext, sink;
	gpio_pkg::pad_s pad;
	gpio_pkg::alt_s alt;
	int bad_count = 0;
	int cmp_count = 0;
	row_s rows [4] = '{48'h00_00_FF_A5_FF_A5, 48'hFF_FF_3C_00_00_3C,
		48'hFF_00_0F_55_0F_05, 48'hF0_F0_A5_3C_0F_AC};
	logic [7:0] regs [4] = '{gpio_pkg::ADDR_DIR, gpio_pkg::ADDR_OPT,
		gpio_pkg::ADDR_SENS, gpio_pkg::ADDR_STAT};

	gpio_port #(.SUPPLY_PINS(8'h80)) i_dut (
		.clk(clk),
		.reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.pin_in(pin_in),
		.pad(pad),
		.alt(alt),
		.alt_in(alt_in),
		.io_supply_ok(io_supply_ok),
		.vector_fetch(vector_fetch),
		.ext_irq(ext_irq)
	);
	pin_model i_pins (.pad(pad), .ext(ext), .sink(sink), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic hang;
		bad_count++;
		final_report();
	endtask : hang

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (s_axi_bvalid !== 1'b1) hang();
		chk("bresp", 8'(e), 8'(s_axi_bresp));
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (s_axi_rvalid !== 1'b1) hang();
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd

	task automatic cfg(input logic [7:0] v, input logic [7:0] o, input logic [7:0] dr);
		wr(gpio_pkg::ADDR_DATA, v, gpio_pkg::RESP_OKAY);
		wr(gpio_pkg::ADDR_OPT, o, gpio_pkg::RESP_OKAY);
		wr(gpio_pkg::ADDR_DIR, dr, gpio_pkg::RESP_OKAY);
		repeat (6) @(posedge clk);
	endtask : cfg

	task automatic pulse_fetch;
		vector_fetch <= 1'b1;
		@(posedge clk);
		vector_fetch <= 1'b0;
	endtask : pulse_fetch

	task automatic wait_irq(input logic [7:0] e);
		repeat (6) @(posedge clk);
		chk("irq", e, 8'(ext_irq));
	endtask : wait_irq

	initial begin
		reset_n = 1'b0;
		s_axi_wstrb = 4'hF;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, alt, ext, sink} = '0;
		{io_supply_ok, vector_fetch} = '0;
		repeat (10) @(posedge clk);
		chk("rst_oen", 8'h7F, pad.oe_n);
		chk("rst_out", 8'h00, pad.out);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (regs[i]) begin
			rd(regs[i]);
			chk("reset", 8'h00, d[7:0]);
			chk("rresp", 8'(gpio_pkg::RESP_OKAY), 8'(r));
		end
		chk("det", 8'h01, 8'(d[8]));
		cfg(8'h80, 8'h80, 8'h80);
		chk("rail", 8'h00, 8'({pad.oe_n[7], pad.out[7]}));
		io_supply_ok <= 1'b1;
		repeat (6) @(posedge clk);
		chk("rail", 8'h01, 8'({pad.oe_n[7], pad.out[7]}));
		foreach (rows[i]) begin
			ext <= rows[i].ext;
			cfg(rows[i].dat, rows[i].opt, rows[i].dir);
			chk("oe_n", rows[i].oen, pad.oe_n);
			chk("out", rows[i].dat & ~rows[i].oen, pad.out & ~rows[i].oen);
			rd(gpio_pkg::ADDR_DATA);
			chk("read", rows[i].rd, d[7:0]);
		end
		// claim, is_out, push_pull, out_val: pin 2 open-drain high floats
		alt <= 32'h05050105;
		ext <= 8'h00;
		cfg(8'h00, 8'h00, 8'h00);
		chk("alt_oen", 8'h06, pad.oe_n & 8'h07);
		chk("alt_out", 8'h01, pad.out & 8'h01);
		rd(gpio_pkg::ADDR_DATA);
		chk("alt_rd", 8'h05, d[7:0] & 8'h05);
		alt <= 32'h0A000000;
		ext <= 8'h08;
		sink <= 8'h02;
		cfg(8'h02, 8'h02, 8'h02);
		chk("alt_in", 8'h0A, alt_in & 8'h0A);
		rd(gpio_pkg::ADDR_DATA);
		chk("sunk", 8'h08, d[7:0] & 8'h0A);
		{alt, sink} <= '0;
		wr(gpio_pkg::ADDR_SENS, 8'(gpio_pkg::SENS_RISE), gpio_pkg::RESP_OKAY);
		wr(gpio_pkg::ADDR_DIR, 8'h00, gpio_pkg::RESP_OKAY);
		ext <= 8'h01;
		wr(gpio_pkg::ADDR_OPT, 8'h03, gpio_pkg::RESP_OKAY);
		// earlier rows left a request pending: drop it before judging
		pulse_fetch();
		wait_irq(8'h00);
		rd(gpio_pkg::ADDR_STAT);
		chk("masked", 8'h00, 8'(d[8]));
		ext <= 8'h03;
		wait_irq(8'h01);
		pulse_fetch();
		wait_irq(8'h00);
		ext <= 8'h02;
		// let the low pin 0 reach the detector before its enable goes
		repeat (4) @(posedge clk);
		wr(gpio_pkg::ADDR_OPT, 8'h02, gpio_pkg::RESP_OKAY);
		wait_irq(8'h01);
		wr(gpio_pkg::ADDR_SENS, 8'(gpio_pkg::SENS_FALL), gpio_pkg::RESP_OKAY);
		pulse_fetch();
		wait_irq(8'h00);
		ext <= 8'h00;
		wait_irq(8'h01);
		wr(gpio_pkg::ADDR_SENS, 8'(gpio_pkg::SENS_BOTH), gpio_pkg::RESP_OKAY);
		pulse_fetch();
		wait_irq(8'h00);
		ext <= 8'h02;
		wait_irq(8'h01);
		wr(8'h14, 8'h00, gpio_pkg::RESP_SLVERR);
		rd(8'h14);
		chk("rresp", 8'(gpio_pkg::RESP_SLVERR), 8'(r));
		final_report();
	end
endmodule : gpio_port_with_ext_interrupt_test
`default_nettype wire
